/* src/ep_buf_pkg.sv */
// How it works
// - Control status stage replies NAK when status bit is 0, else ZLP or ACK.
// - Status bit clears itself when the status stage completes or a SETUP arrives.
// - Stall bit makes the endpoint answer STALL, except on isochronous endpoints.
// - Stall keeps the data toggle; an enable off-then-on restarts it at DATA0.
// - Each port write to an IN endpoint whose buffer is neither armed nor full advances the TX pointer by 2 or 4 bytes.
// - TX buffer is validated by itself when its byte count reaches max packet size, or a smaller nonzero packet size.
// - The validate command arms a short TX buffer for the next IN token.
// - Each port read from an OUT endpoint whose buffer is full moves the RX pointer by 2 or 4 bytes.
// - RX buffer empties by itself once every received byte has been read.
// - The flush command empties the RX buffer even when not fully read.
// - Writing the max packet size loads the packet size with that max packet size value.
// - A USB bus reset forces the packet size to zero.
// - TX buffer is validated when its byte count reaches the packet size value, or max packet size if that is smaller or packet size is zero.
// - On an OUT endpoint each acknowledged packet loads its byte count as packet size.
// - On a 16-bit bus the last odd byte is returned in the low byte lane.
// - The packet size register is 16 bits and resets to zero.
// - The FIFO port is 32 or 16 bits wide and reads zero after reset.
// - Port, size and control act on the endpoint picked by index and direction.
`default_nettype none
package ep_buf_pkg;
  localparam logic [11:0] REG_PACKET_SIZE = 12'h21c;
  localparam logic [11:0] REG_FIFO_PORT = 12'h220;
  localparam logic [11:0] REG_BUFFER_CONTROL = 12'h228;
  localparam int CTL_STALL = 0;
  localparam int CTL_STATUS_ACK = 1;
  localparam int CTL_DATA_STAGE = 2;
  localparam int CTL_VALIDATE = 3;
  localparam int CTL_FLUSH = 4;
  localparam logic [15:0] PACKET_SIZE_RESET = 16'h0000;
  localparam logic [31:0] FIFO_PORT_RESET = 32'h0000_0000;
  localparam logic [15:0] STEP_WIDE = 16'h0004;
  localparam logic [15:0] STEP_NARROW = 16'h0002;
  localparam logic [3:0] CONTROL_ENDPOINT = 4'h0;
  localparam int CLK_PERIOD_NS = 4;
  localparam int DATA_WAIT_NS = 500;
  localparam int DATA_WAIT_CYCLES = (DATA_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {TOK_OUT = 2'b00, TOK_IN = 2'b01, TOK_SETUP = 2'b10} token_kind_e;
  typedef enum logic [2:0] {
    RPL_ACK = 3'b000, RPL_NAK = 3'b001, RPL_STALL = 3'b010, RPL_ZLP = 3'b011, RPL_DATA = 3'b100
  } reply_code_e;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_SEND = 2'b01, ST_RECV = 2'b10} link_state_e;

  typedef struct packed {
    logic valid;
    token_kind_e kind;
    logic status_stage;
  } token_s;
  typedef struct packed {
    logic valid;
    reply_code_e code;
  } reply_s;
  typedef struct packed {
    logic [31:0] data;
    logic [2:0] bytes;
    logic last;
  } tx_word_s;
  typedef struct packed {
    logic [31:0] data;
    logic [15:0] count;
    logic last;
  } rx_word_s;
endpackage
`default_nettype wire

/* src/word_pair_buffer.sv */
`default_nettype none
module word_pair_buffer #(
  parameter int WIDTH = 36
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  logic [WIDTH-1:0] spare;
  logic spare_valid;

  if (WIDTH < 1) begin : g_bad_width
    $error("WIDTH must be at least 1");
  end

  // Ready depends only on the spare entry, so no combinational path from out_ready_in
  assign in_ready_out = !spare_valid;

  always_ff @(posedge clk_in) begin
    if (in_valid_in && in_ready_out && out_valid_out && !out_ready_in) begin
      spare <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      spare_valid <= 1'b0;
      out_valid_out <= 1'b0;
      out_data_out <= '0;
    end else if (out_ready_in || !out_valid_out) begin
      if (spare_valid) begin
        out_data_out <= spare;
        out_valid_out <= 1'b1;
        spare_valid <= 1'b0;
      end else begin
        out_data_out <= in_data_in;
        out_valid_out <= in_valid_in;
      end
    end else if (in_valid_in && in_ready_out) begin
      spare_valid <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* src/endpoint_buffer_access.sv */
`default_nettype none
module endpoint_buffer_access #(
  parameter int FIFO_WORDS = 16
) (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic usb_bus_reset_in,
  input wire logic bus_wide_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [31:0] reg_wdata_in,
  output logic [31:0] reg_rdata_out,
  input wire logic [3:0] target_endpoint_select_in,
  input wire logic endpoint_is_in_in,
  input wire logic endpoint_iso_in,
  input wire logic endpoint_enable_in,
  input wire logic max_size_wr_in,
  input wire logic [10:0] max_size_in,
  input wire ep_buf_pkg::token_s token_in,
  input wire logic host_ack_in,
  output ep_buf_pkg::reply_s reply_out,
  input wire ep_buf_pkg::rx_word_s rx_word_in,
  input wire logic rx_valid_in,
  output logic rx_ready_out,
  output ep_buf_pkg::tx_word_s tx_word_out,
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  output logic [15:0] packet_byte_count_out,
  output logic stall_out,
  output logic status_ack_out,
  output logic data_toggle_out,
  output logic tx_armed_out,
  output logic rx_full_out
);
  import ep_buf_pkg::*;

  localparam int AW = $clog2(FIFO_WORDS);
  localparam logic [15:0] FIFO_BYTES = 16'(FIFO_WORDS * 4);

  if (FIFO_WORDS < 2 || FIFO_WORDS > 512 || (FIFO_WORDS & (FIFO_WORDS - 1)) != 0) begin : g_bad_depth
    $error("FIFO_WORDS must be a power of two from 2 to 512");
  end

  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] offset);
    return addr == offset;
  endfunction

  logic [15:0] tx_lo [FIFO_WORDS];
  logic [15:0] tx_hi [FIFO_WORDS];
  logic [31:0] rx_mem [FIFO_WORDS];

  link_state_e state;
  logic [15:0] tx_count, tx_len, send_ptr, rx_rptr, rx_left;
  logic [AW-1:0] rx_wptr;
  logic data_stage, zlp_wait, enable_seen;

  logic wr_size, wr_port, rd_port, wr_ctl, rd_size, rd_ctl, is_ctl, stall_eff;
  logic tx_wr, auto_valid, validate_tx_buffer, flush_rx_buffer, rx_rd, rx_take, recv_done;
  logic tx_push, skid_ready, tx_release, tok_live, setup_seen, in_acked;
  logic [15:0] step, next_count, tx_limit, send_left;
  logic [31:0] rx_word, rx_read, read_mux;
  tx_word_s push_word;

  logic next_reply_valid, start_send, start_recv, zlp_release, status_done, status_zlp;
  reply_code_e next_reply;

  assign step = bus_wide_in ? STEP_WIDE : STEP_NARROW;
  // Every access acts on the endpoint picked by index and direction
  assign is_ctl = target_endpoint_select_in == CONTROL_ENDPOINT;
  assign wr_size = reg_wr_in && reg_hit(reg_addr_in, REG_PACKET_SIZE);
  assign wr_port = reg_wr_in && reg_hit(reg_addr_in, REG_FIFO_PORT);
  assign wr_ctl = reg_wr_in && reg_hit(reg_addr_in, REG_BUFFER_CONTROL);
  assign rd_size = reg_rd_in && reg_hit(reg_addr_in, REG_PACKET_SIZE);
  assign rd_port = reg_rd_in && reg_hit(reg_addr_in, REG_FIFO_PORT);
  assign rd_ctl = reg_rd_in && reg_hit(reg_addr_in, REG_BUFFER_CONTROL);
  assign stall_eff = stall_out && !endpoint_iso_in;

  // Writes into an armed buffer or past the array end are dropped
  assign tx_wr = wr_port && endpoint_is_in_in && !tx_armed_out && (tx_count < FIFO_BYTES);
  assign next_count = tx_count + step;
  assign tx_limit = (packet_byte_count_out != 16'h0000 && packet_byte_count_out < {5'h00, max_size_in}) ?
                    packet_byte_count_out : {5'h00, max_size_in};
  assign auto_valid = tx_wr && next_count >= tx_limit;
  assign validate_tx_buffer = wr_ctl && reg_wdata_in[CTL_VALIDATE] && endpoint_is_in_in;
  assign flush_rx_buffer = wr_ctl && reg_wdata_in[CTL_FLUSH] && !endpoint_is_in_in;
  assign rx_rd = rd_port && !endpoint_is_in_in && rx_full_out;
  assign rx_take = rx_valid_in && rx_ready_out;
  assign recv_done = rx_take && rx_word_in.last;
  assign tok_live = token_in.valid && state == ST_IDLE;
  assign setup_seen = token_in.valid && token_in.kind == TOK_SETUP;
  assign in_acked = host_ack_in && !zlp_wait;

  assign send_left = tx_len - send_ptr;
  assign tx_push = state == ST_SEND && skid_ready;
  assign tx_release = (tx_push && push_word.last) || zlp_release;

  always_comb begin
    push_word.data = {tx_hi[send_ptr[AW+1:2]], tx_lo[send_ptr[AW+1:2]]};
    push_word.bytes = (send_left >= 16'h0004) ? 3'h4 : send_left[2:0];
    push_word.last = send_left <= 16'h0004;
  end

  always_comb begin
    next_reply_valid = 1'b0;
    next_reply = RPL_NAK;
    start_send = 1'b0;
    start_recv = 1'b0;
    zlp_release = 1'b0;
    status_done = 1'b0;
    status_zlp = 1'b0;
    if (tok_live && token_in.kind != TOK_SETUP) begin
      next_reply_valid = 1'b1;
      if (stall_eff) begin
        next_reply = RPL_STALL;
      end else if (is_ctl && token_in.status_stage) begin
        if (!status_ack_out) begin
          next_reply = RPL_NAK;
        end else if (token_in.kind == TOK_IN) begin
          next_reply = RPL_ZLP;
          status_zlp = 1'b1;
        end else begin
          next_reply = RPL_ACK;
          status_done = 1'b1;
        end
      end else if (is_ctl && !data_stage) begin
        next_reply = RPL_NAK;
      end else if (token_in.kind == TOK_IN) begin
        if (!tx_armed_out) begin
          next_reply = RPL_NAK;
        end else if (tx_len == 16'h0000) begin
          next_reply = RPL_ZLP;
          zlp_release = 1'b1;
        end else begin
          next_reply = RPL_DATA;
          start_send = 1'b1;
        end
      end else if (rx_full_out) begin
        next_reply = RPL_NAK;
      end else begin
        next_reply_valid = 1'b0;
        start_recv = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
      rx_ready_out <= 1'b0;
      send_ptr <= 16'h0000;
      rx_wptr <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          send_ptr <= 16'h0000;
          if (start_send) begin
            state <= ST_SEND;
          end else if (start_recv) begin
            state <= ST_RECV;
            rx_ready_out <= 1'b1;
            rx_wptr <= '0;
          end
        end
        ST_SEND: begin
          if (tx_push) begin
            send_ptr <= send_ptr + 16'h0004;
            if (push_word.last) begin
              state <= ST_IDLE;
            end
          end
        end
        ST_RECV: begin
          if (rx_take) begin
            rx_wptr <= rx_wptr + 1'b1;
          end
          if (recv_done) begin
            state <= ST_IDLE;
            rx_ready_out <= 1'b0;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reply_out <= '0;
    end else begin
      reply_out.valid <= next_reply_valid || recv_done;
      reply_out.code <= recv_done ? RPL_ACK : next_reply;
    end
  end

  always_ff @(posedge clk_in) begin
    if (tx_wr) begin
      if (bus_wide_in || !tx_count[1]) begin
        tx_lo[tx_count[AW+1:2]] <= reg_wdata_in[15:0];
      end
      if (bus_wide_in) begin
        tx_hi[tx_count[AW+1:2]] <= reg_wdata_in[31:16];
      end else if (tx_count[1]) begin
        tx_hi[tx_count[AW+1:2]] <= reg_wdata_in[15:0];
      end
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      tx_count <= 16'h0000;
      tx_len <= 16'h0000;
      tx_armed_out <= 1'b0;
    end else if (tx_release) begin
      tx_count <= 16'h0000;
      tx_armed_out <= 1'b0;
    end else if (tx_wr) begin
      tx_count <= next_count;
      if (auto_valid) begin
        tx_armed_out <= 1'b1;
        tx_len <= (next_count > tx_limit) ? tx_limit : next_count;
      end
    end else if (validate_tx_buffer && !tx_armed_out) begin
      tx_armed_out <= 1'b1;
      tx_len <= tx_count;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rx_take) begin
      rx_mem[rx_wptr] <= rx_word_in.data;
    end
  end

  // A packet that lands in the flush cycle survives: the fill wins over the clear
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_full_out <= 1'b0;
      rx_left <= 16'h0000;
      rx_rptr <= 16'h0000;
    end else if (recv_done) begin
      rx_full_out <= rx_word_in.count != 16'h0000;
      rx_left <= rx_word_in.count;
      rx_rptr <= 16'h0000;
    end else if (flush_rx_buffer || (rx_rd && rx_left <= step)) begin
      rx_full_out <= 1'b0;
      rx_left <= 16'h0000;
      rx_rptr <= 16'h0000;
    end else if (rx_rd) begin
      rx_left <= rx_left - step;
      rx_rptr <= rx_rptr + step;
    end
  end

  assign rx_word = rx_mem[rx_rptr[AW+1:2]];
  always_comb begin
    if (!rx_full_out) begin
      rx_read = FIFO_PORT_RESET;
    end else if (bus_wide_in) begin
      rx_read = rx_word;
    end else if (rx_left == 16'h0001) begin
      rx_read = {24'h000000, rx_rptr[1] ? rx_word[23:16] : rx_word[7:0]};
    end else begin
      rx_read = {16'h0000, rx_rptr[1] ? rx_word[31:16] : rx_word[15:0]};
    end
  end

  always_comb begin
    if (rd_port) begin
      read_mux = endpoint_is_in_in ? FIFO_PORT_RESET : rx_read;
    end else if (rd_size) begin
      read_mux = {16'h0000, packet_byte_count_out};
    end else if (rd_ctl) begin
      read_mux = {30'h00000000, status_ack_out, stall_out};
    end else begin
      read_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= FIFO_PORT_RESET;
    end else if (reg_rd_in) begin
      reg_rdata_out <= read_mux;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      packet_byte_count_out <= PACKET_SIZE_RESET;
    end else if (usb_bus_reset_in) begin
      packet_byte_count_out <= PACKET_SIZE_RESET;
    end else if (wr_size) begin
      packet_byte_count_out <= reg_wdata_in[15:0];
    end else if (max_size_wr_in) begin
      packet_byte_count_out <= {5'h00, max_size_in};
    end else if (recv_done) begin
      packet_byte_count_out <= rx_word_in.count;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stall_out <= 1'b0;
      data_stage <= 1'b0;
    end else if (usb_bus_reset_in) begin
      stall_out <= 1'b0;
      data_stage <= 1'b0;
    end else begin
      if (wr_ctl) begin
        stall_out <= reg_wdata_in[CTL_STALL];
      end
      if (wr_ctl && reg_wdata_in[CTL_DATA_STAGE]) begin
        data_stage <= 1'b1;
      end else if (is_ctl && (recv_done || in_acked)) begin
        data_stage <= 1'b0;
      end
    end
  end

  // Software relies on data stages being finished before it sets this bit
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      status_ack_out <= 1'b0;
      zlp_wait <= 1'b0;
    end else if (usb_bus_reset_in) begin
      status_ack_out <= 1'b0;
      zlp_wait <= 1'b0;
    end else begin
      if (wr_ctl) begin
        status_ack_out <= reg_wdata_in[CTL_STATUS_ACK];
      end else if (setup_seen || status_done || (zlp_wait && host_ack_in)) begin
        status_ack_out <= 1'b0;
      end
      if (status_zlp) begin
        zlp_wait <= 1'b1;
      end else if (host_ack_in || setup_seen) begin
        zlp_wait <= 1'b0;
      end
    end
  end

  // Stall never touches the toggle; only an enable rising edge restarts it
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      enable_seen <= 1'b0;
      data_toggle_out <= 1'b0;
    end else begin
      enable_seen <= endpoint_enable_in;
      if (endpoint_enable_in && !enable_seen) begin
        data_toggle_out <= 1'b0;
      end else if (recv_done || in_acked) begin
        data_toggle_out <= !data_toggle_out;
      end
    end
  end

  word_pair_buffer #(
    .WIDTH($bits(tx_word_s))
  ) u_tx_skid (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .in_data_in(push_word),
    .in_valid_in(tx_push),
    .in_ready_out(skid_ready),
    .out_data_out(tx_word_out),
    .out_valid_out(tx_valid_out),
    .out_ready_in(tx_ready_in)
  );

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_status_in_ok;
    tok_live && is_ctl && token_in.status_stage && token_in.kind == TOK_IN && status_ack_out && !stall_eff;
  endsequence
  sequence s_zlp_pending;
    reply_out.valid && reply_out.code == RPL_ZLP && zlp_wait;
  endsequence
  property p_status_zlp;
    s_status_in_ok |=> s_zlp_pending;
  endproperty
  a_status_zlp: assert property (p_status_zlp) else $error("status IN did not get a pending ZLP");
  property p_status_nak;
    tok_live && is_ctl && token_in.status_stage && token_in.kind != TOK_SETUP && !status_ack_out && !stall_eff
      |=> reply_out.valid && reply_out.code == RPL_NAK;
  endproperty
  a_status_nak: assert property (p_status_nak) else $error("status stage without ack bit not NAKed");
  property p_status_clear;
    (zlp_wait && host_ack_in || setup_seen) && !wr_ctl |=> !status_ack_out;
  endproperty
  a_status_clear: assert property (p_status_clear) else $error("status bit not cleared");
  property p_stall_reply;
    tok_live && token_in.kind != TOK_SETUP && stall_out && !endpoint_iso_in
      |=> reply_out.valid && reply_out.code == RPL_STALL;
  endproperty
  a_stall_reply: assert property (p_stall_reply) else $error("stalled endpoint did not STALL");
  property p_toggle_restart;
    endpoint_enable_in && !enable_seen |=> !data_toggle_out;
  endproperty
  a_toggle_restart: assert property (p_toggle_restart) else $error("toggle not restarted on enable");
  property p_tx_step;
    tx_wr && !tx_release |=> tx_count == $past(tx_count) + $past(step);
  endproperty
  a_tx_step: assert property (p_tx_step) else $error("TX pointer step wrong");
  property p_auto_valid;
    auto_valid && !tx_release |=> tx_armed_out && tx_len <= $past(tx_limit);
  endproperty
  a_auto_valid: assert property (p_auto_valid) else $error("TX buffer not validated at limit");
  property p_rx_step;
    rx_rd && rx_left > step && !flush_rx_buffer |=> rx_left == $past(rx_left) - $past(step) && rx_full_out;
  endproperty
  a_rx_step: assert property (p_rx_step) else $error("RX count step wrong");
  property p_rx_clear;
    (rx_rd && rx_left <= step || flush_rx_buffer) && state != ST_RECV |=> !rx_full_out && rx_rptr == 16'h0000;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("RX buffer not cleared");
  property p_bus_reset_size;
    usb_bus_reset_in |=> packet_byte_count_out == PACKET_SIZE_RESET;
  endproperty
  a_bus_reset_size: assert property (p_bus_reset_size) else $error("bus reset left packet size");
  property p_rx_count_load;
    recv_done && !usb_bus_reset_in && !wr_size && !max_size_wr_in
      |=> packet_byte_count_out == $past(rx_word_in.count) && reply_out.valid && reply_out.code == RPL_ACK;
  endproperty
  a_rx_count_load: assert property (p_rx_count_load) else $error("OUT count not loaded");
  property p_odd_low_lane;
    rx_rd && !bus_wide_in && rx_left == 16'h0001 && rd_port |=> reg_rdata_out[31:8] == 24'h000000;
  endproperty
  a_odd_low_lane: assert property (p_odd_low_lane) else $error("odd byte not in low lane");
endmodule
`default_nettype wire

/* testbench/usb_host_model.sv */
`default_nettype none
module usb_host_model (
  input wire logic clk_in,
  input wire ep_buf_pkg::reply_s reply_in,
  input wire ep_buf_pkg::tx_word_s tx_word_in,
  input wire logic tx_valid_in,
  input wire logic rx_ready_in,
  output ep_buf_pkg::token_s token_out,
  output logic host_ack_out,
  output ep_buf_pkg::rx_word_s rx_word_out,
  output logic rx_valid_out,
  output logic tx_ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import ep_buf_pkg::*;
  int got = 0;
  logic [31:0] last_data;
  logic [2:0] last_bytes;
  initial begin
    token_out = '0;
    host_ack_out = 1'b0;
    rx_word_out = '0;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
  end
  // Ready on alternate cycles only, so the TX path must absorb stalls
  always @(negedge clk_in) tx_ready_out <= ~tx_ready_out;
  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out) begin
      got++;
      last_data <= tx_word_in.data;
      last_bytes <= tx_word_in.bytes;
    end
  end
  task automatic reply(output logic [2:0] c);
    c = 3'h7;
    for (int i = 0; i < 40 && c == 3'h7; i++) begin
      if (reply_in.valid) c = reply_in.code;
      else @(negedge clk_in);
    end
  endtask
  task automatic token(input token_kind_e k, input logic s);
    @(negedge clk_in);
    token_out = '{1'b1, k, s};
    @(negedge clk_in);
    token_out = '0;
  endtask
  task automatic pkt(input logic [31:0] d, input logic [15:0] n, input logic s, output logic [2:0] c);
    token(TOK_OUT, s);
    rx_word_out = '{d, n, 1'b1};
    rx_valid_out = 1'b1;
    for (int i = 0; i < 40 && !rx_ready_in; i++) @(negedge clk_in);
    @(negedge clk_in);
    rx_valid_out = 1'b0;
    // A released line must not keep showing the old word
    rx_word_out = ~rx_word_out;
    reply(c);
  endtask
  task automatic ack;
    @(negedge clk_in);
    host_ack_out = 1'b1;
    @(negedge clk_in);
    host_ack_out = 1'b0;
  endtask
endmodule
`default_nettype wire

/* testbench/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ep_buf_pkg::*;
  logic clk_in = 1'b0, sys_rst_in = 1'b1, usb_bus_reset_in = 1'b0, bus_wide_in = 1'b1;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, endpoint_is_in_in = 1'b1, endpoint_iso_in = 1'b0;
  logic endpoint_enable_in = 1'b1, max_size_wr_in = 1'b0;
  logic [11:0] reg_addr_in = 12'h000;
  logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
  logic [3:0] target_endpoint_select_in = 4'h1;
  logic [10:0] max_size_in = 11'h008;
  logic [15:0] packet_byte_count_out;
  logic rx_ready_out, tx_valid_out, host_ack_in, rx_valid_in, tx_ready_in;
  logic stall_out, status_ack_out, data_toggle_out, tx_armed_out, rx_full_out;
  token_s token_in;
  reply_s reply_out;
  rx_word_s rx_word_in;
  tx_word_s tx_word_out;
  int bad_count = 0, checked = 0;
  logic [2:0] code;
  endpoint_buffer_access i_dut (.clk_in, .sys_rst_in, .usb_bus_reset_in, .bus_wide_in, .reg_addr_in, .reg_wr_in,
    .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .target_endpoint_select_in, .endpoint_is_in_in, .endpoint_iso_in,
    .endpoint_enable_in, .max_size_wr_in, .max_size_in, .token_in, .host_ack_in, .reply_out, .rx_word_in,
    .rx_valid_in, .rx_ready_out, .tx_word_out, .tx_valid_out, .tx_ready_in, .packet_byte_count_out, .stall_out,
    .status_ack_out, .data_toggle_out, .tx_armed_out, .rx_full_out);
  usb_host_model h (.clk_in, .reply_in(reply_out), .tx_word_in(tx_word_out), .tx_valid_in(tx_valid_out),
    .rx_ready_in(rx_ready_out), .token_out(token_in), .host_ack_out(host_ack_in), .rx_word_out(rx_word_in),
    .rx_valid_out(rx_valid_in), .tx_ready_out(tx_ready_in));
  initial forever #2 clk_in = ~clk_in;
  task automatic chk(input logic [31:0] g, e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic close_out;
    $display("mismatches %0d comparisons %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic bus(input logic [11:0] a, input logic [31:0] d, input logic w);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = w;
    reg_rd_in = !w;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    @(negedge clk_in);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(a, 32'h0, 1'b0);
    chk(reg_rdata_out, e);
  endtask
  task automatic flag(input logic g, e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task automatic tok(input token_kind_e k, input logic s, input reply_code_e e);
    h.token(k, s);
    h.reply(code);
    chk({29'h0, code}, {29'h0, e});
  endtask
  task automatic pkt(input logic [31:0] d, input logic [15:0] n);
    h.pkt(d, n, 1'b0, code);
    chk({29'h0, code}, {29'h0, RPL_ACK});
  endtask
  task automatic drain(input int n);
    for (int i = 0; i < 60 && h.got < n; i++) @(negedge clk_in);
    if (h.got < n) begin
      bad_count++;
      close_out;
    end
    h.ack;
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    @(negedge clk_in);
    sys_rst_in = 1'b0;
    rd(REG_PACKET_SIZE, 32'h0);
    rd(REG_FIFO_PORT, 32'h0);
    max_size_wr_in = 1'b1;
    @(negedge clk_in);
    max_size_wr_in = 1'b0;
    rd(REG_PACKET_SIZE, 32'h8);
    bus_wide_in = 1'b0;
    for (int i = 0; i < 4; i++) begin
      flag(tx_armed_out, 1'b0);
      bus(REG_FIFO_PORT, 32'h1111 * i, 1'b1);
    end
    flag(tx_armed_out, 1'b1);
    tok(TOK_IN, 1'b0, RPL_DATA);
    drain(2);
    chk(h.last_data, 32'h3333_2222);
    flag(tx_armed_out, 1'b0);
    flag(data_toggle_out, 1'b1);
    bus(REG_BUFFER_CONTROL, 32'h1, 1'b1);
    flag(stall_out, 1'b1);
    tok(TOK_IN, 1'b0, RPL_STALL);
    flag(data_toggle_out, 1'b1);
    endpoint_iso_in = 1'b1;
    tok(TOK_IN, 1'b0, RPL_NAK);
    endpoint_iso_in = 1'b0;
    bus(REG_BUFFER_CONTROL, 32'h0, 1'b1);
    flag(stall_out, 1'b0);
    endpoint_enable_in = 1'b0;
    repeat (2) @(negedge clk_in);
    endpoint_enable_in = 1'b1;
    repeat (2) @(negedge clk_in);
    flag(data_toggle_out, 1'b0);
    bus_wide_in = 1'b1;
    bus(REG_PACKET_SIZE, 32'h6, 1'b1);
    bus(REG_FIFO_PORT, 32'ha1a2_a3a4, 1'b1);
    flag(tx_armed_out, 1'b0);
    bus(REG_FIFO_PORT, 32'hb1b2_b3b4, 1'b1);
    flag(tx_armed_out, 1'b1);
    tok(TOK_IN, 1'b0, RPL_DATA);
    drain(4);
    chk(h.last_data, 32'hb1b2_b3b4);
    chk({29'h0, h.last_bytes}, 32'h0000_0002);
    bus(REG_FIFO_PORT, 32'hc1c2_c3c4, 1'b1);
    flag(tx_armed_out, 1'b0);
    bus(REG_BUFFER_CONTROL, 32'h8, 1'b1);
    flag(tx_armed_out, 1'b1);
    tok(TOK_IN, 1'b0, RPL_DATA);
    drain(5);
    chk(h.last_data, 32'hc1c2_c3c4);
    target_endpoint_select_in = CONTROL_ENDPOINT;
    tok(TOK_IN, 1'b1, RPL_NAK);
    bus(REG_BUFFER_CONTROL, 32'h2, 1'b1);
    rd(REG_BUFFER_CONTROL, 32'h2);
    tok(TOK_IN, 1'b1, RPL_ZLP);
    h.ack;
    flag(status_ack_out, 1'b0);
    bus(REG_BUFFER_CONTROL, 32'h2, 1'b1);
    h.token(TOK_SETUP, 1'b0);
    repeat (2) @(negedge clk_in);
    flag(status_ack_out, 1'b0);
    target_endpoint_select_in = 4'h1;
    endpoint_is_in_in = 1'b0;
    bus_wide_in = 1'b0;
    pkt(32'h00cc_bbaa, 16'h0003);
    flag(rx_full_out, 1'b1);
    rd(REG_PACKET_SIZE, 32'h3);
    repeat (DATA_WAIT_CYCLES) @(negedge clk_in);
    rd(REG_FIFO_PORT, 32'hbbaa);
    rd(REG_FIFO_PORT, 32'hcc);
    flag(rx_full_out, 1'b0);
    bus_wide_in = 1'b1;
    pkt(32'h4433_2211, 16'h0004);
    flag(rx_full_out, 1'b1);
    bus(REG_BUFFER_CONTROL, 32'h10, 1'b1);
    flag(rx_full_out, 1'b0);
    target_endpoint_select_in = CONTROL_ENDPOINT;
    tok(TOK_OUT, 1'b0, RPL_NAK);
    bus(REG_BUFFER_CONTROL, 32'h4, 1'b1);
    pkt(32'h0000_0055, 16'h0001);
    flag(rx_full_out, 1'b1);
    bus(REG_BUFFER_CONTROL, 32'h10, 1'b1);
    flag(rx_full_out, 1'b0);
    bus(REG_BUFFER_CONTROL, 32'h2, 1'b1);
    tok(TOK_OUT, 1'b1, RPL_ACK);
    flag(status_ack_out, 1'b0);
    usb_bus_reset_in = 1'b1;
    @(negedge clk_in);
    usb_bus_reset_in = 1'b0;
    rd(REG_PACKET_SIZE, 32'h0);
    rd(12'h300, 32'h0);
    close_out;
  end
  initial begin
    #100000;
    bad_count++;
    close_out;
  end
endmodule
`default_nettype wire
